//--- hw/tcx_pkg.sv
/*
  Constants for the two-input preset counter: register map, field
  positions, reset values, mode encodings and timing figures.
  Assumes a 10 MHz register clock.
*/
package tcx_pkg;
  localparam int CLK_KHZ = 10000;
  localparam int SHOT_MS = 1000;
  localparam int SHOT_CYC = SHOT_MS * CLK_KHZ;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_COUNT = 8'h04;
  localparam logic [7:0] A_SET1 = 8'h08;
  localparam logic [7:0] A_SET2 = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;

  localparam int CTL_IM = 0;
  localparam int CTL_O1 = 3;
  localparam int CTL_O2 = 5;
  localparam int CTL_CLR = 8;

  localparam int ST_OUT1 = 0;
  localparam int ST_OUT2 = 1;
  localparam int ST_FIRST = 2;
  localparam int ST_SECOND = 3;

  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] SET_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    IM_UP = 3'h0,
    IM_DOWN = 3'h1,
    IM_DIR = 3'h3,
    IM_SEP = 3'h2,
    IM_PHASE = 3'h6
  } tcx_inmode_t;

  typedef enum logic [2:0] {
    OM_HOLD_A = 3'h0,
    OM_HOLD_B = 3'h1,
    OM_HOLD_C = 3'h2,
    OM_HOLD_D = 3'h3,
    OM_SHOT_A = 3'h4,
    OM_SHOT_B = 3'h5,
    OM_SHOT_C = 3'h6,
    OM_SHOT_D = 3'h7
  } tcx_outmode_t;
endpackage : tcx_pkg

//--- hw/tcx_counter.sv
/*
  Two-input preset counter: input synchronisers, the input modes
  (gated up, gated down, direction, separate up/down, phase), two
  set values with their output modes, and an APB register slave.
  Assumes the pulse sources respect the minimum signal width and
  that the bus master follows APB signalling.
*/
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RULE1 - Down mode: second input pulses decrement; first input high blocks them.
// RULE2 - Direction mode: first input counts, second low adds, high subtracts.
// RULE3 - Source keeps direction change well ahead of the next counting edge.
// RULE4 - Separate mode: first input increments, second input decrements.
// RULE5 - Separate mode: both inputs accepted at any time, fully independent; edges on both in one cycle cancel here, count unchanged.
// RULE6 - Phase mode: first leading adds, second leading subtracts.
// RULE7 - Source keeps the phase offset above the minimum signal width.
// RULE8 - Set value 1 offers four output modes: over count I-III, one shot.
// RULE9 - Set value 2 offers eight output modes, hold, over, recount, shot.
// RULE10 - Source pulses stay above the minimum width of the chosen speed.
// RULE11 - Gated modes: one input blocks counts of the other input.
// RULE12 - Inputs synchronised; one count per qualified edge, applied next cycle.
module tcx_counter #(
  parameter int CW = 16,
  parameter int TW = 24,
  parameter int SHOT_CYCLES = tcx_pkg::SHOT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_pulse_input,
  input wire logic second_pulse_input,
  output logic ctrl_out1,
  output logic ctrl_out2
);

  typedef struct packed {
    logic [2:0] sa;
    logic [2:0] sb;
    logic fa;
    logic fb;
    logic ra;
    logic rb;
    tcx_pkg::tcx_inmode_t im;
    logic [1:0] o1m;
    tcx_pkg::tcx_outmode_t o2m;
    logic [CW-1:0] count;
    logic [CW-1:0] set1;
    logic [CW-1:0] set2;
    logic out1;
    logic out2;
    logic [TW-1:0] tmr1;
    logic [TW-1:0] tmr2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tcx_state_t;

  localparam logic [TW-1:0] SHOT_LEN = TW'(SHOT_CYCLES);
  localparam logic [TW-1:0] TMR_LAST = TW'(1);

  tcx_state_t q;
  tcx_state_t n;
  logic up;
  logic dn;
  logic blk;
  logic chg;
  logic hit1;
  logic hit2;
  logic rc;
  logic wr;
  logic prep;
  logic err;
  logic quiet;
  logic [CW-1:0] cnt_s;
  logic [31:0] rsel;
  tcx_pkg::tcx_outmode_t m1;

  // Set value 1 only has four of the eight output modes.
  function automatic tcx_pkg::tcx_outmode_t o1_map(
    input logic [1:0] f
  );
    case (f)
      2'h0: o1_map = tcx_pkg::OM_HOLD_B;
      2'h1: o1_map = tcx_pkg::OM_HOLD_C;
      2'h2: o1_map = tcx_pkg::OM_HOLD_D;
      default: o1_map = tcx_pkg::OM_SHOT_A;
    endcase
  endfunction : o1_map

  function automatic logic is_shot(input tcx_pkg::tcx_outmode_t m);
    is_shot = m[2];
  endfunction : is_shot

  // Next {output, shot timer} of one set-value comparator.
  function automatic logic [TW:0] out_nxt(
    input tcx_pkg::tcx_outmode_t m,
    input logic o,
    input logic [TW-1:0] t,
    input logic hit,
    input logic step,
    input logic ge
  );
    logic on;
    logic [TW-1:0] tn;
    on = o;
    tn = t;
    case (m)
      tcx_pkg::OM_HOLD_A, tcx_pkg::OM_HOLD_B: on = o | hit;
      tcx_pkg::OM_HOLD_C: begin
        if (hit) begin
          on = 1'b1;
        end else if (step) begin
          on = 1'b0;
        end
      end
      tcx_pkg::OM_HOLD_D: on = ge;
      default: begin
        if (hit) begin
          on = 1'b1;
          tn = SHOT_LEN;
        end else if (t > TMR_LAST) begin
          tn = t - TMR_LAST;
        end else if (t == TMR_LAST) begin
          tn = '0;
          on = 1'b0;
        end
      end
    endcase
    out_nxt = {on, tn};
  endfunction : out_nxt

  always_comb begin
    n = q;
    n.pready = 1'b0;
    m1 = o1_map(q.o1m);
    wr = psel & penable & pwrite & q.pready & ~q.pslverr;
    prep = psel & penable & ~q.pready;

    // Three-stage synchronisers; a level is accepted once the
    // second and third stages agree, which also rejects one-cycle
    // glitches that slip past the first stage.
    n.sa = {q.sa[1:0], first_pulse_input};
    n.sb = {q.sb[1:0], second_pulse_input};
    if (q.sa[1] == q.sa[2]) begin
      n.fa = q.sa[2]; // see RULE12
    end
    if (q.sb[1] == q.sb[2]) begin
      n.fb = q.sb[2]; // see RULE12
    end
    n.ra = n.fa & ~q.fa; // see RULE12
    n.rb = n.fb & ~q.fb; // see RULE12

    // Count decision, one cycle after the qualified edge.
    up = 1'b0;
    dn = 1'b0;
    case (q.im)
      tcx_pkg::IM_UP: up = q.ra & ~q.fb; // see RULE11
      tcx_pkg::IM_DOWN: dn = q.rb & ~q.fa; // see RULE1 see RULE11
      tcx_pkg::IM_DIR: begin
        up = q.ra & ~q.fb; // see RULE2
        dn = q.ra & q.fb; // see RULE2
      end
      tcx_pkg::IM_SEP: begin
        up = q.ra; // see RULE4 see RULE5
        dn = q.rb; // see RULE4 see RULE5
      end
      tcx_pkg::IM_PHASE: begin
        up = q.ra & ~q.fb; // see RULE6
        dn = q.rb & ~q.fa; // see RULE6
      end
      default: ;
    endcase

    // Hold-count modes freeze the count while output 2 is on.
    blk = q.out2 & ((q.o2m == tcx_pkg::OM_HOLD_A) |
                    (q.o2m == tcx_pkg::OM_SHOT_D)); // see RULE9
    chg = (up ^ dn) & ~blk;
    cnt_s = q.count;
    if (chg & up) begin
      cnt_s = q.count + CW'(1); // see RULE12
    end else if (chg) begin
      cnt_s = q.count - CW'(1); // see RULE12
    end
    hit1 = chg & (cnt_s == q.set1);
    hit2 = chg & (cnt_s == q.set2);

    {n.out1, n.tmr1} = out_nxt(m1, q.out1, q.tmr1, hit1, chg,
                               cnt_s >= q.set1); // see RULE8
    {n.out2, n.tmr2} = out_nxt(q.o2m, q.out2, q.tmr2, hit2, chg,
                               cnt_s >= q.set2); // see RULE9
    n.count = cnt_s;

    // Recount I restarts at once, recount II when the shot ends.
    rc = 1'b0;
    if ((q.o2m == tcx_pkg::OM_SHOT_B) && hit2) begin
      rc = 1'b1; // see RULE9
    end
    if ((q.o2m == tcx_pkg::OM_SHOT_C) && (q.tmr2 == TMR_LAST)) begin
      rc = 1'b1; // see RULE9
    end
    if (rc) begin
      n.count = '0;
    end
    quiet = ~wr & ~rc;

    // Register read mux and address decode.
    rsel = '0;
    err = 1'b0;
    case (paddr)
      tcx_pkg::A_CTRL: begin
        rsel[tcx_pkg::CTL_IM +: 3] = q.im;
        rsel[tcx_pkg::CTL_O1 +: 2] = q.o1m;
        rsel[tcx_pkg::CTL_O2 +: 3] = q.o2m;
      end
      tcx_pkg::A_COUNT: rsel = 32'(q.count);
      tcx_pkg::A_SET1: rsel = 32'(q.set1);
      tcx_pkg::A_SET2: rsel = 32'(q.set2);
      tcx_pkg::A_STAT: begin
        rsel[tcx_pkg::ST_OUT1] = q.out1;
        rsel[tcx_pkg::ST_OUT2] = q.out2;
        rsel[tcx_pkg::ST_FIRST] = q.fa;
        rsel[tcx_pkg::ST_SECOND] = q.fb;
      end
      default: err = 1'b1;
    endcase
    if (prep) begin
      n.pready = 1'b1;
      n.pslverr = err;
      n.prdata = pwrite ? 32'h0000_0000 : rsel;
    end

    // A bus write takes effect at the completing edge and wins
    // over any count made in the same cycle.
    if (wr) begin
      case (paddr)
        tcx_pkg::A_CTRL: begin
          n.im = tcx_pkg::tcx_inmode_t'(pwdata[tcx_pkg::CTL_IM +: 3]);
          n.o1m = pwdata[tcx_pkg::CTL_O1 +: 2]; // see RULE8
          n.o2m = tcx_pkg::tcx_outmode_t'(
            pwdata[tcx_pkg::CTL_O2 +: 3]); // see RULE9
          if (pwdata[tcx_pkg::CTL_CLR]) begin
            n.count = '0;
            n.out1 = 1'b0;
            n.out2 = 1'b0;
            n.tmr1 = '0;
            n.tmr2 = '0;
          end
        end
        tcx_pkg::A_COUNT: begin
          n.count = pwdata[CW-1:0];
          n.out1 = 1'b0;
          n.out2 = 1'b0;
          n.tmr1 = '0;
          n.tmr2 = '0;
        end
        tcx_pkg::A_SET1: n.set1 = pwdata[CW-1:0];
        tcx_pkg::A_SET2: n.set2 = pwdata[CW-1:0];
        default: n.pslverr = q.pslverr;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.count <= tcx_pkg::COUNT_RST[CW-1:0];
      q.set1 <= tcx_pkg::SET_RST[CW-1:0];
      q.set2 <= tcx_pkg::SET_RST[CW-1:0];
    end else if (ce) begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign ctrl_out1 = q.out1;
  assign ctrl_out2 = q.out2;

  default clocking cb @(posedge pclk iff ce);
  endclocking
  default disable iff (!presetn);

  a_down_gate: assert property ( // see RULE1
    q.im == tcx_pkg::IM_DOWN && q.rb && !q.fa && !blk && quiet
    |=> q.count == CW'($past(q.count) - CW'(1)))
    else $error("down mode missed a count");
  a_gate_block: assert property ( // see RULE11
    q.im == tcx_pkg::IM_UP && q.fb && quiet |=> $stable(q.count))
    else $error("gate did not block the count");
  a_dir_sense: assert property ( // see RULE2
    q.im == tcx_pkg::IM_DIR && q.ra && !blk && quiet
    |=> q.count == ($past(q.fb) ? CW'($past(q.count) - CW'(1)) :
                    CW'($past(q.count) + CW'(1))))
    else $error("direction select ignored");
  a_sep_count: assert property ( // see RULE4
    q.im == tcx_pkg::IM_SEP && q.ra && !q.rb && !blk && quiet
    |=> q.count == CW'($past(q.count) + CW'(1)))
    else $error("separate up input did not add");
  a_sep_both: assert property ( // see RULE5
    q.im == tcx_pkg::IM_SEP && q.ra && q.rb && quiet
    |=> $stable(q.count))
    else $error("simultaneous up and down not cancelled");
  a_phase_lead: assert property ( // see RULE6
    q.im == tcx_pkg::IM_PHASE && q.rb && !q.fa && !blk && quiet
    |=> q.count == CW'($past(q.count) - CW'(1)))
    else $error("second input leading did not subtract");
  a_edge_once: assert property ( // see RULE12
    $rose(q.fa) |-> q.ra ##1 !q.ra)
    else $error("edge pulse not exactly one cycle");
  a_hold1_keep: assert property ( // see RULE8
    q.out1 && m1 == tcx_pkg::OM_HOLD_B && !wr |=> q.out1)
    else $error("output 1 hold released early");
  a_shot2_end: assert property ( // see RULE9
    q.out2 && is_shot(q.o2m) && q.tmr2 == TMR_LAST && !hit2 && !wr
    |=> !q.out2 && q.tmr2 == '0)
    else $error("output 2 shot did not end");
  a_hold2_freeze: assert property ( // see RULE9
    q.out2 && q.o2m == tcx_pkg::OM_HOLD_A && !wr ##1 !wr
    |-> $stable(q.count) [*2])
    else $error("count moved while held");

  c_phase_cnt: cover property (q.im == tcx_pkg::IM_PHASE && chg);
  c_hit1: cover property (hit1 ##1 q.out1);
  c_recount: cover property (rc && q.o2m == tcx_pkg::OM_SHOT_B);

endmodule : tcx_counter

`default_nettype wire

//--- testbench/tcx_src.sv
/*
  Pulse source model for the two-input counter: two sensor style
  lines, each level held for a whole number of clock cycles.
  Assumes the caller enters a step right after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module tcx_src #(
  parameter int MINW = 4
) (
  input wire logic clk,
  output logic p1 = 1'b0,
  output logic p2 = 1'b0
);
  // Every level, and so every offset between the lines, lasts MINW at
  // least, because a shorter pulse may be lost in the synchronisers.
  task automatic step(input logic a, input logic b, input int w);
    p1 <= a;
    p2 <= b;
    repeat ((w < MINW) ? MINW : w) @(posedge clk);
  endtask : step
endmodule : tcx_src
`default_nettype wire

//--- testbench/tcx_counter_bench.sv
/*
  Self-checking bench of the two-input counter: an integer model of
  the input modes is compared with the count read back over APB.
  Assumes the pulse source model tcx_src and one wait state on APB.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tcx_counter_bench;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, out1, out2, pulse_a, pulse_b, pa = 0, pb = 0;
  logic [15:0] mc = 16'h0000;
  logic [2:0] m;
  logic [2:0] modes [5] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h0};
  int n_mismatch = 0, cmp_count = 0, seed = 33, i, j;
  always #50 pclk = ~pclk;
  tcx_counter #(.SHOT_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_pulse_input(pulse_a),
    .second_pulse_input(pulse_b), .ctrl_out1(out1), .ctrl_out2(out2));
  tcx_src src_u (.clk(pclk), .p1(pulse_a), .p2(pulse_b));
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (k >= 20) begin
      n_mismatch++;
      summarize();
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  // One source step; the model counts from the edges it creates.
  task automatic go(input logic a, input logic b);
    logic r1, r2;
    r1 = a & !pa;
    r2 = b & !pb;
    src_u.step(a, b, 8);
    case (m)
      3'h0: if (r1 && !b) mc += 1;
      3'h1: if (r2 && !a) mc -= 1;
      3'h3: if (r1) mc = b ? mc - 1 : mc + 1;
      3'h2: mc = mc + r1 - r2;
      3'h6: begin
        if (r1 && !b) mc += 1;
        if (r2 && !a) mc -= 1;
      end
      default: ;
    endcase
    pa = a;
    pb = b;
    apb(0, tcx_pkg::A_COUNT, 32'h0);
    `CHK(rd[15:0], mc)
  endtask : go
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 5; i++) begin
      apb(0, 8'(i * 4), 32'h0);
      `CHK(rd, 32'h0000_0000)
    end
    apb(1, 8'h14, 32'hFFFF_FFFF);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    for (i = 0; i < 8; i++) begin
      apb(1, tcx_pkg::A_CTRL, 32'((i << 5) | ((i & 3) << 3) | 2));
      apb(0, tcx_pkg::A_CTRL, 32'h0);
      `CHK(rd, 32'((i << 5) | ((i & 3) << 3) | 2))
    end
    for (i = 0; i < 5; i++) begin
      m = modes[i];
      // Out2 latches instead of holding, so counting is never blocked.
      apb(1, tcx_pkg::A_CTRL, {24'h00_0000, 3'h1, 2'h0, m});
      mc = 16'($random(seed));
      apb(1, tcx_pkg::A_COUNT, {16'h0000, mc});
      go(0, 0);
      if (m == 3'h2) go(1, 1);
      for (j = 0; j < 12; j++) begin
        if ($random(seed) & 1) go(!pa, pb);
        else go(pa, !pb);
      end
    end
    m = 3'h2;
    apb(1, tcx_pkg::A_CTRL, 32'h0000_0002);
    apb(1, tcx_pkg::A_SET1, 32'h0000_0006);
    apb(1, tcx_pkg::A_SET2, 32'h0000_0100);
    apb(1, tcx_pkg::A_COUNT, 32'h0000_0005);
    mc = 16'h0005;
    go(0, 0);
    go(1, 0);
    go(0, 0);
    go(0, 1);
    `CHK(out1, 1'b1)
    apb(1, tcx_pkg::A_CTRL, 32'h0000_0102);
    apb(0, tcx_pkg::A_COUNT, 32'h0);
    `CHK({out1, rd[15:0]}, 17'h0_0000)
    // With the clock enable low a whole pulse must go unseen.
    mc = 16'h0000;
    ce <= 1'b0;
    src_u.step(1'b1, 1'b1, 8);
    src_u.step(1'b0, 1'b1, 8);
    ce <= 1'b1;
    apb(0, tcx_pkg::A_COUNT, 32'h0);
    `CHK(rd[15:0], mc)
    // Hold count: reaching set value 2 latches output 2 and stops counting.
    apb(1, tcx_pkg::A_SET2, 32'h0000_0001);
    go(1, 1);
    `CHK(out2, 1'b1)
    go(0, 1);
    src_u.step(1'b1, 1'b1, 8);
    pa = 1'b1;
    apb(0, tcx_pkg::A_COUNT, 32'h0);
    `CHK(rd[15:0], mc)
    apb(0, tcx_pkg::A_STAT, 32'h0);
    `CHK(rd, 32'h0000_000E)
    // One shot: output 2 pulses for the shot length, counting goes on.
    apb(1, tcx_pkg::A_CTRL, 32'h0000_0182);
    mc = 16'h0000;
    go(0, 0);
    go(1, 0);
    `CHK(out2, 1'b1)
    repeat (24) @(posedge pclk);
    `CHK(out2, 1'b0)
    summarize();
  end
  initial begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end
endmodule : tcx_counter_bench
`default_nettype wire
